// ---- design/perf_evsel_defines.vh ----
// event numbers, mask bits and state codes for the event-select decoder
// assumes inclusion by bare name from the design files
`ifndef PERF_EVSEL_DEFINES_VH
`define PERF_EVSEL_DEFINES_VH

`define EV_L2_OWNERSHIP      8'h27
`define EV_L1_WRITEBACK      8'h28
`define EV_LAST_LEVEL        8'h2e
`define EV_UNHALTED          8'h3c
`define EV_L1_READS          8'h40
`define EV_L1_STORE_OWN      8'h41

`define MASK_LL_REFERENCE    8'h4f
`define MASK_LL_MISS         8'h41
`define MASK_THREAD_CYCLES   8'h00
`define MASK_REF_CYCLES      8'h01
`define MASK_STORE_SHARED    8'h02

// lock qualifiers live in the upper nibble
`define LOCK_NIBBLE_LSB      4
`define LOCK_NIBBLE_MSB      7

// line state codes carried with the lock, writeback, read and store events
`define ST_INVALID           2'h0
`define ST_SHARED            2'h1
`define ST_EXCLUSIVE         2'h2
`define ST_MODIFIED          2'h3

`endif

// ---- design/state_mask_match.v ----
// two-bit line state code qualified by a four-bit mask nibble
// assumes state code valid whenever the event pulse is high
`timescale 1ns/1ps
`include "perf_evsel_defines.vh"
module state_mask_match (
  event_valid,
  line_state,
  mask_nibble,
  hit
);
  input  wire       event_valid;
  input  wire [1:0] line_state;
  input  wire [3:0] mask_nibble;
  output wire       hit;

  // bit0 invalid, bit1 shared, bit2 exclusive, bit3 modified
  assign hit = event_valid & mask_nibble[line_state];
endmodule // state_mask_match

// ---- design/perf_event_select_decoder.v ----
// event-select decoder feeding one performance counter increment
// assumes event pulses are one cycle, synchronous to clk, one per event
//
// Operation
// - event 27h, mask S/E/M bits: count locked ownership hits in those states
// - event 27h, all four state bits: count every locked ownership request
// - event 28h counts first-level writebacks; mask bits 01h..08h pick I,S,E,M
// - event 28h with all four state bits counts every writeback once
// - event 2eh mask 4fh counts last-level references, prefetch fills excluded
// - event 2eh mask 41h counts last-level misses, prefetch fills excluded
// - thread cycle selection counts each clock while not halted
// - reference cycle selection counts at time-stamp rate while not halted
// - event 40h counts first-level reads; mask bits 01h..08h pick I,S,E,M
// - event 40h with all four state bits counts every read request
// - event 41h mask 02h counts store ownership requests to shared lines
// - event 27h lock qualifiers: 10h I, 20h S, 40h E, 80h M
`timescale 1ns/1ps
`include "perf_evsel_defines.vh"
module perf_event_select_decoder (
  clk,
  rst_n,
  event_select,
  unit_mask,
  lock_own_valid,
  lock_own_state,
  writeback_valid,
  writeback_state,
  ll_reference_valid,
  ll_miss_valid,
  ll_from_l2_prefetch,
  l1_read_valid,
  l1_read_state,
  store_own_valid,
  store_own_state,
  halt_instruction,
  wake_event,
  time_stamp_tick,
  count_inc,
  thread_halted
);
  input  wire       clk;
  input  wire       rst_n;
  input  wire [7:0] event_select;
  input  wire [7:0] unit_mask;
  input  wire       lock_own_valid;
  input  wire [1:0] lock_own_state;
  input  wire       writeback_valid;
  input  wire [1:0] writeback_state;
  input  wire       ll_reference_valid;
  input  wire       ll_miss_valid;
  input  wire       ll_from_l2_prefetch;
  input  wire       l1_read_valid;
  input  wire [1:0] l1_read_state;
  input  wire       store_own_valid;
  input  wire [1:0] store_own_state;
  input  wire       halt_instruction;
  input  wire       wake_event;
  input  wire       time_stamp_tick;
  output reg        count_inc;
  output reg        thread_halted;

  ////////////////////////////////////////////////////////////////////////
  // halt tracking
  reg halted_q;
  reg halted_d;

  always @* begin
    halted_d = halted_q;
    if (wake_event)
      halted_d = 1'b0;
    // halt wins: a halt and a wake together leave the thread halted
    if (halt_instruction)
      halted_d = 1'b1;
  end

  always @(posedge clk or negedge rst_n) begin
    if (!rst_n)
      halted_q <= 1'b0;
    else
      halted_q <= halted_d;
  end

  ////////////////////////////////////////////////////////////////////////
  // state-qualified sources
  wire lock_hit;
  wire wb_hit;
  wire rd_hit;

  state_mask_match u_lock (
    .event_valid (lock_own_valid),
    .line_state  (lock_own_state),
    .mask_nibble (unit_mask[`LOCK_NIBBLE_MSB:`LOCK_NIBBLE_LSB]),
    .hit         (lock_hit)
  );

  state_mask_match u_wb (
    .event_valid (writeback_valid),
    .line_state  (writeback_state),
    .mask_nibble (unit_mask[3:0]),
    .hit         (wb_hit)
  );

  state_mask_match u_rd (
    .event_valid (l1_read_valid),
    .line_state  (l1_read_state),
    .mask_nibble (unit_mask[3:0]),
    .hit         (rd_hit)
  );

  ////////////////////////////////////////////////////////////////////////
  // sizes; the ports keep the documented widths
  parameter EVENT_W = 8;
  parameter MASK_W  = 8;
  parameter STATE_W = 2;

  ////////////////////////////////////////////////////////////////////////
  // decode helpers
  // pure compares plus a prefetch gate; the event and mask compares are shared by several events

  // exact event compare
  function event_is;
    input [EVENT_W-1:0] sel;
    input [EVENT_W-1:0] code;
    begin
      event_is = (sel == code);
    end
  endfunction

  // exact mask compare; partial masks never match
  function mask_is;
    input [MASK_W-1:0] mask;
    input [MASK_W-1:0] code;
    begin
      mask_is = (mask == code);
    end
  endfunction

  // line state compare
  function state_is;
    input [STATE_W-1:0] state;
    input [STATE_W-1:0] code;
    begin
      state_is = (state == code);
    end
  endfunction

  // occurrence that is not a second-level prefetch fill
  function demand_only;
    input occurred;
    input from_prefetch;
    begin
      demand_only = occurred & ~from_prefetch;
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////
  // event and mask matches, decoded once
  wire sel_lock;
  wire sel_wb;
  wire sel_ll;
  wire sel_cyc;
  wire sel_rd;
  wire sel_st;
  wire mask_ll_ref;
  wire mask_ll_miss;
  wire mask_thread;
  wire mask_ref;
  wire mask_st_shared;

  assign sel_lock       = event_is(event_select, `EV_L2_OWNERSHIP);
  assign sel_wb         = event_is(event_select, `EV_L1_WRITEBACK);
  assign sel_ll         = event_is(event_select, `EV_LAST_LEVEL);
  assign sel_cyc        = event_is(event_select, `EV_UNHALTED);
  assign sel_rd         = event_is(event_select, `EV_L1_READS);
  assign sel_st         = event_is(event_select, `EV_L1_STORE_OWN);

  // unlisted masks on these events are silently ignored
  assign mask_ll_ref    = mask_is(unit_mask, `MASK_LL_REFERENCE);
  assign mask_ll_miss   = mask_is(unit_mask, `MASK_LL_MISS);
  assign mask_thread    = mask_is(unit_mask, `MASK_THREAD_CYCLES);
  assign mask_ref       = mask_is(unit_mask, `MASK_REF_CYCLES);
  assign mask_st_shared = mask_is(unit_mask, `MASK_STORE_SHARED);

  ////////////////////////////////////////////////////////////////////////
  // per-event candidates; event codes differ, so at most one is high
  reg lock_cand;
  reg wb_cand;
  reg ll_cand;
  reg cyc_cand;
  reg rd_cand;
  reg st_cand;
  reg inc_d;

  // state qualifiers applied by the upper-nibble match
  always @* begin
    lock_cand = 1'b0;
    if (sel_lock) begin
      lock_cand = lock_hit;
    end else begin
      lock_cand = 1'b0;
    end
  end

  // any writeback state
  // state split done in the match instance
  always @* begin
    wb_cand = 1'b0;
    if (sel_wb) begin
      wb_cand = wb_hit;
    end else begin
      wb_cand = 1'b0;
    end
  end

  always @* begin
    ll_cand = 1'b0;
    if (sel_ll) begin
      // speculative traffic counts; only the prefetch fill is dropped
      if (mask_ll_ref)
        ll_cand = demand_only(ll_reference_valid, ll_from_l2_prefetch);
      else if (mask_ll_miss)
        ll_cand = demand_only(ll_miss_valid, ll_from_l2_prefetch);
      else
        ll_cand = 1'b0;
    end
  end

  // cycle counts see the registered halt, so the halt cycle still counts
  always @* begin
    cyc_cand = 1'b0;
    if (sel_cyc) begin
      if (mask_thread)
        cyc_cand = ~halted_q;
      else if (mask_ref)
        cyc_cand = ~halted_q & time_stamp_tick;
      else
        cyc_cand = 1'b0;
    end
  end

  // any read state
  // state split done in the match instance
  always @* begin
    rd_cand = 1'b0;
    if (sel_rd) begin
      rd_cand = rd_hit;
    end else begin
      rd_cand = 1'b0;
    end
  end

  // shared store ownership
  // other masks on this event give no increment
  always @* begin
    st_cand = 1'b0;
    if (sel_st && mask_st_shared) begin
      st_cand = store_own_valid & state_is(store_own_state, `ST_SHARED);
    end else begin
      st_cand = 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // event selection

  always @* begin
    inc_d = lock_cand | wb_cand | ll_cand | cyc_cand | rd_cand | st_cand;
  end

  ////////////////////////////////////////////////////////////////////////
  // registered outputs: one cycle latency traded for flop-driven pins

  // count_inc one cycle after the qualifying input
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      count_inc <= 1'b0;
    end else begin
      count_inc <= inc_d;
    end
  end

  // thread_halted mirrors the halt state register
  // reset leaves the thread running
  always @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      thread_halted <= 1'b0;
    end else begin
      thread_halted <= halted_d;
    end
  end
endmodule // perf_event_select_decoder

// ---- verification/perf_evsel_checker_assertions.sv ----
// checker: port relations of the event-select decoder
// assumes bind onto the decoder, ports matched by name
`timescale 1ns/1ps
module perf_evsel_checker (
  input wire logic clk, rst_n, lock_own_valid, writeback_valid, ll_reference_valid,
  input wire logic ll_miss_valid, ll_from_l2_prefetch, l1_read_valid, store_own_valid,
  input wire logic halt_instruction, wake_event, time_stamp_tick, count_inc, thread_halted,
  input wire logic [7:0] event_select, unit_mask,
  input wire logic [1:0] lock_own_state, writeback_state, l1_read_state, store_own_state
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  wire [7:0] e = event_select, m = unit_mask;
  a_lock_count: assert property (e == 8'h27 && lock_own_valid && m[4 + lock_own_state]
    |=> count_inc) else $error("lock count");
  a_wb_count: assert property (e == 8'h28 && writeback_valid && m[writeback_state]
    |=> count_inc) else $error("wb count");
  a_ll_ref: assert property (e == 8'h2e && m == 8'h4f && ll_reference_valid
    && !ll_from_l2_prefetch |=> count_inc) else $error("ll ref");
  a_ll_prefetch: assert property (e == 8'h2e && ll_from_l2_prefetch
    |=> !count_inc) else $error("ll prefetch");
  a_thread_cycles: assert property (e == 8'h3c && m == 8'h00 && !thread_halted
    |=> count_inc) else $error("thread cyc");
  a_ref_tick: assert property (e == 8'h3c && m == 8'h01 && !time_stamp_tick
    |=> !count_inc) else $error("ref tick");
  a_read_count: assert property (e == 8'h40 && l1_read_valid && m[l1_read_state]
    |=> count_inc) else $error("read count");
  a_store_shared: assert property (e == 8'h41 && m == 8'h02 && store_own_valid
    && store_own_state == 2'h1 |=> count_inc) else $error("store");
  c_halt: cover property (halt_instruction ##1 thread_halted);
  c_lock: cover property (e == 8'h27 && lock_own_valid);
  c_tick: cover property (e == 8'h3c && m == 8'h01 && time_stamp_tick);
endmodule // perf_evsel_checker
bind perf_event_select_decoder perf_evsel_checker perf_evsel_checker_i (.*);

// ---- verification/event_source_model.sv ----
// far side: cache, pipeline and halt event sources
// assumes at most one event pulse per cycle, plus the reference that comes with a miss; states change every cycle
`timescale 1ns/1ps
module event_source_model (
  input wire logic clk,
  output logic lock_own_valid = 0, writeback_valid = 0, ll_reference_valid = 0,
  output logic ll_miss_valid = 0, ll_from_l2_prefetch = 0, l1_read_valid = 0,
  output logic store_own_valid = 0, halt_instruction = 0, wake_event = 0, time_stamp_tick = 0,
  output logic [1:0] lock_own_state = 0, writeback_state = 0, l1_read_state = 0,
  output logic [1:0] store_own_state = 0
);
  int k;
  always @(posedge clk) begin
    k = $urandom % 16;
    lock_own_valid <= k == 0;
    writeback_valid <= k == 1;
    // a miss is also a reference
    ll_reference_valid <= k == 2 || k == 3;
    ll_miss_valid <= k == 3;
    ll_from_l2_prefetch <= $urandom % 2;
    l1_read_valid <= k == 4;
    store_own_valid <= k == 5;
    halt_instruction <= k == 6;
    wake_event <= k == 7;
    time_stamp_tick <= $urandom % 3 == 0;
    {lock_own_state, writeback_state, l1_read_state, store_own_state} <= 8'($urandom);
  end
endmodule // event_source_model

// ---- verification/perf_event_select_decoder_tb_top.sv ----
// bench: random event traffic against a cycle model of the decoder
// assumes the source model drives all cache and halt inputs
`timescale 1ns/1ps
module perf_event_select_decoder_tb_top;
  logic clk = 0, rst_n = 0, exp_q = 0, hlt_q = 0;
  logic [7:0] event_select = 0, unit_mask = 0;
  wire lock_own_valid, writeback_valid, ll_reference_valid, ll_miss_valid, ll_from_l2_prefetch;
  wire l1_read_valid, store_own_valid, halt_instruction, wake_event, time_stamp_tick;
  wire count_inc, thread_halted;
  wire [1:0] lock_own_state, writeback_state, l1_read_state, store_own_state;
  int n_mismatch = 0, comparisons = 0;
  logic [15:0] sel [12] = '{16'h27e0, 16'h27f0, 16'h2801, 16'h280f, 16'h2e4f, 16'h2e41,
    16'h3c00, 16'h3c01, 16'h400f, 16'h4002, 16'h4102, 16'h2620};
  perf_event_select_decoder perf_event_select_decoder_i (.*);
  event_source_model event_source_model_i (.*);
  initial forever #2.5 clk = ~clk;
  function logic f(logic [7:0] e, logic [7:0] m);
    case (e)
      8'h27: f = lock_own_valid & m[4 + lock_own_state];
      8'h28: f = writeback_valid & m[writeback_state];
      8'h2e: f = !ll_from_l2_prefetch & (m == 8'h4f ? ll_reference_valid
                 : m == 8'h41 & ll_miss_valid);
      8'h3c: f = !hlt_q & (m == 8'h00 | m == 8'h01 & time_stamp_tick);
      8'h40: f = l1_read_valid & m[l1_read_state];
      8'h41: f = m == 8'h02 & store_own_valid & store_own_state == 2'h1;
      default: f = 0;
    endcase
  endfunction
  always @(posedge clk) begin
    exp_q <= rst_n && f(event_select, unit_mask);
    hlt_q <= rst_n && (halt_instruction || (hlt_q && !wake_event));
  end
  task check(string what, logic seen, logic exp);
    comparisons++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("ERROR %s expected %b seen %b", what, exp, seen);
    end
  endtask
  always @(negedge clk) if (rst_n) begin
    check("count_inc", count_inc, exp_q);
    check("thread_halted", thread_halted, hlt_q);
  end
  task report_and_stop;
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  initial begin
    void'($urandom(32'heeef8267));
    repeat (10) @(posedge clk);
    rst_n <= 1;
    for (int i = 0; i < 24; i++) begin
      @(posedge clk);
      event_select <= sel[i % 12][15:8];
      unit_mask <= i < 12 ? sel[i % 12][7:0] : 8'($urandom);
      // second reset in mid-run
      if (i == 18) rst_n <= 0;
      repeat (300) @(posedge clk);
      rst_n <= 1;
      $display("test %0d done", i);
    end
    report_and_stop;
  end
  initial begin
    #100000;
    n_mismatch++;
    report_and_stop;
  end
endmodule // perf_event_select_decoder_tb_top
